// >>> common/eit_pkg.sv
// Purpose: shared constants and types for the external interrupt flag block
// Assumes: apb register map of one aligned 32-bit word per register
// Notes:   offsets below are byte addresses
package eit_pkg;

    // =========================================================
    // sizes
    localparam int NUM_EXT_IRQ = 2;
    localparam int APB_AW      = 8;
    localparam int APB_DW      = 32;

    // =========================================================
    // register byte offsets
    localparam logic [APB_AW-1:0] CTRL_OFF  = 8'h00;
    localparam logic [APB_AW-1:0] CFG_OFF   = 8'h04;
    localparam logic [APB_AW-1:0] GATE_OFF  = 8'h08;
    localparam logic [APB_AW-1:0] STAT_OFF  = 8'h0c;
    localparam logic [APB_AW-1:0] MASK_OFF  = 8'h10;
    localparam logic [APB_AW-1:0] STATE_OFF = 8'h14;

    // =========================================================
    // control register field positions (8-bit register)
    localparam int CTRL_IT0 = 0;
    localparam int CTRL_IE0 = 1;
    localparam int CTRL_IT1 = 2;
    localparam int CTRL_IE1 = 3;
    localparam int CTRL_TR0 = 4;

    // config, gate and state register field positions
    localparam int CFG_POL0     = 0;
    localparam int CFG_POL1     = 1;
    localparam int GATE_SEL0    = 0;
    localparam int STATE_ACT0   = 0;
    localparam int STATE_ACT1   = 1;
    localparam int STATE_CNT_EN = 2;

    // =========================================================
    // reset values
    localparam logic             RUN_RST   = 1'b0;
    localparam logic [1:0]       TRIG_RST  = 2'h0;
    localparam logic [1:0]       POL_RST   = 2'h0;
    localparam logic             GATE_RST  = 1'b0;
    localparam logic [1:0]       STAT_RST  = 2'h0;
    localparam logic [1:0]       MASK_RST  = 2'h0;
    localparam logic [APB_DW-1:0] ZERO_WORD = 32'h0000_0000;

    // =========================================================
    // carriers
    typedef struct packed {
        logic edge_mode;
        logic active_high;
    } eit_chan_cfg_t;

    typedef struct packed {
        logic [APB_AW-1:0] addr;
        logic              write;
        logic [APB_DW-1:0] wdata;
    } eit_apb_req_t;

endpackage : eit_pkg

// >>> design/eit_rst_sync.sv
// Purpose: releases an async active-low reset through two flip-flops
// Assumes: one clock domain
// Notes:   assertion is immediate, release is synchronous
`timescale 1ns/10ps
module eit_rst_sync (
    // clock and raw reset
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    // synchronised reset
    output logic      rst_n_out
);
    logic stage_reg;
    logic stage_next;

    // =========================================================
    // chain
    always_comb begin
        stage_next = 1'b1;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage_reg <= 1'b0;
            rst_n_out <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            rst_n_out <= stage_reg;
        end
    end
endmodule : eit_rst_sync

// >>> design/eit_irq_channel.sv
// Purpose: one external interrupt input with pending flag and trigger select
// Assumes: input synchronous to clk_in
// Notes:   hardware set wins over software clear and vector clear
`timescale 1ns/10ps
module eit_irq_channel
    import eit_pkg::*;
(
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    // pin and configuration
    input  wire logic          irq_pin_in,
    input  wire eit_chan_cfg_t cfg_in,
    // software and core
    input  wire logic          sw_write_in,
    input  wire logic          sw_value_in,
    input  wire logic          vector_ack_in,
    // state
    output logic               pending_out,
    output logic               active_out,
    output logic               event_out
);
    logic prev_reg;
    logic prev_next;
    logic pending_reg;
    logic pending_next;
    logic onset;
    logic detect;

    // =========================================================
    // detection
    always_comb begin
        active_out   = cfg_in.active_high ? irq_pin_in : ~irq_pin_in;
        onset        = active_out & ~prev_reg;
        detect       = cfg_in.edge_mode ? onset : active_out;
        event_out    = onset;
        prev_next    = active_out;
        pending_next = pending_reg;
        if (sw_write_in) begin
            pending_next = sw_value_in;
        end
        if (vector_ack_in && cfg_in.edge_mode) begin
            pending_next = 1'b0;
        end
        if (detect) begin
            pending_next = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_reg    <= 1'b0;
            pending_reg <= 1'b0;
        end else begin
            prev_reg    <= prev_next;
            pending_reg <= pending_next;
        end
    end

    assign pending_out = pending_reg;
endmodule : eit_irq_channel

// >>> design/eit_top.sv
// Purpose: external interrupt pending flags, trigger select and timer 0 run gate
// Assumes: apb slave, pins synchronous to clk_in (25 MHz)
// Notes:   control register keeps the classic bit positions of its 8-bit layout
//
// How it works
// - run bit one lets timer 0 count
// - trigger bit zero level, one edge
// - input polarity comes from config register
// - hardware sets pending flag on detection
// - software write loads pending flag from the written bit
// - edge mode: vectoring clears pending flag
// - gate selected: count needs active interrupt 0
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module eit_top
    import eit_pkg::*;
#(
    parameter int NUM_CH = NUM_EXT_IRQ
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    // apb slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [APB_AW-1:0] paddr_in,
    input  wire logic [APB_DW-1:0] pwdata_in,
    output logic      [APB_DW-1:0] prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // external interrupt pins
    input  wire logic              ext_irq0_input_in,
    input  wire logic              ext_irq1_input_in,
    // processor core vectoring
    input  wire logic [NUM_CH-1:0] vector_ack_in,
    output logic      [NUM_CH-1:0] ext_irq_pending_out,
    // timer 0 control
    output logic                   timer0_count_enable_out,
    // summary interrupt
    output logic                   irq_out
);

    // =========================================================
    // elaboration check
    // register layout has room for exactly two channels
    if (NUM_CH != NUM_EXT_IRQ) begin : g_bad_num_ch
        $error("eit_top: NUM_CH must equal NUM_EXT_IRQ");
    end

    // =========================================================
    // reset release
    logic rst_n;

    eit_rst_sync u_rst_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .rst_n_out  (rst_n)
    );

    // =========================================================
    // declarations
    eit_apb_req_t      req;
    logic              setup_phase;
    logic              apb_done;
    logic              addr_mapped;
    logic              wr_ctrl;
    logic              wr_cfg;
    logic              wr_gate;
    logic              wr_stat;
    logic              wr_mask;
    logic [APB_DW-1:0] rd_mux;

    logic              run_reg;
    logic              run_next;
    logic [1:0]        trig_reg;
    logic [1:0]        trig_next;
    logic [1:0]        pol_reg;
    logic [1:0]        pol_next;
    logic              gate_reg;
    logic              gate_next;
    logic [1:0]        stat_reg;
    logic [1:0]        stat_next;
    logic [1:0]        mask_reg;
    logic [1:0]        mask_next;
    logic              cnt_en_reg;
    logic              cnt_en_next;
    logic              irq_reg;
    logic              irq_next;

    logic [APB_DW-1:0] prdata_reg;
    logic [APB_DW-1:0] prdata_next;
    logic              pready_reg;
    logic              pready_next;
    logic              pslverr_reg;
    logic              pslverr_next;

    logic [NUM_CH-1:0] pin_vec;
    logic [NUM_CH-1:0] pend_vec;
    logic [NUM_CH-1:0] act_vec;
    logic [NUM_CH-1:0] evt_vec;
    logic [NUM_CH-1:0] sw_val_vec;

    // =========================================================
    // apb decode
    always_comb begin
        req.addr    = paddr_in;
        req.write   = pwrite_in;
        req.wdata   = pwdata_in;
        setup_phase = psel_in & ~penable_in;
        apb_done    = psel_in & penable_in & pready_reg;
        addr_mapped = (req.addr == CTRL_OFF) || (req.addr == CFG_OFF)
                   || (req.addr == GATE_OFF) || (req.addr == STAT_OFF)
                   || (req.addr == MASK_OFF) || (req.addr == STATE_OFF);
        wr_ctrl     = apb_done & req.write & (req.addr == CTRL_OFF);
        wr_cfg      = apb_done & req.write & (req.addr == CFG_OFF);
        wr_gate     = apb_done & req.write & (req.addr == GATE_OFF);
        wr_stat     = apb_done & req.write & (req.addr == STAT_OFF);
        wr_mask     = apb_done & req.write & (req.addr == MASK_OFF);
    end

    // =========================================================
    // read mux
    // unused upper bits of every register read as zero
    always_comb begin
        rd_mux = ZERO_WORD;
        unique case (req.addr)
            CTRL_OFF: begin
                rd_mux[CTRL_IT0] = trig_reg[0];
                rd_mux[CTRL_IE0] = pend_vec[0];
                rd_mux[CTRL_IT1] = trig_reg[1];
                rd_mux[CTRL_IE1] = pend_vec[1];
                rd_mux[CTRL_TR0] = run_reg;
            end
            CFG_OFF: begin
                rd_mux[CFG_POL0] = pol_reg[0];
                rd_mux[CFG_POL1] = pol_reg[1];
            end
            GATE_OFF: begin
                rd_mux[GATE_SEL0] = gate_reg;
            end
            STAT_OFF: begin
                rd_mux[NUM_CH-1:0] = stat_reg;
            end
            MASK_OFF: begin
                rd_mux[NUM_CH-1:0] = mask_reg;
            end
            STATE_OFF: begin
                rd_mux[STATE_ACT0]   = act_vec[0];
                rd_mux[STATE_ACT1]   = act_vec[1];
                rd_mux[STATE_CNT_EN] = cnt_en_reg;
            end
            default: begin
                rd_mux = ZERO_WORD;
            end
        endcase
    end

    // =========================================================
    // apb answer
    // one access cycle: ready is raised straight after setup
    always_comb begin
        pready_next  = setup_phase;
        pslverr_next = setup_phase & ~addr_mapped;
        prdata_next  = (setup_phase & ~req.write) ? rd_mux : ZERO_WORD;
        if (apb_done) begin
            pready_next  = 1'b0;
            pslverr_next = 1'b0;
            prdata_next  = ZERO_WORD;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= ZERO_WORD;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // =========================================================
    // external interrupt channels
    always_comb begin
        pin_vec[0]    = ext_irq0_input_in;
        pin_vec[1]    = ext_irq1_input_in;
        sw_val_vec[0] = req.wdata[CTRL_IE0];
        sw_val_vec[1] = req.wdata[CTRL_IE1];
    end

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        eit_chan_cfg_t chan_cfg;

        always_comb begin
            chan_cfg.edge_mode   = trig_reg[ch];
            chan_cfg.active_high = pol_reg[ch];
        end

        eit_irq_channel u_chan (
            .clk_in        (clk_in),
            .rst_n_in      (rst_n),
            .irq_pin_in    (pin_vec[ch]),
            .cfg_in        (chan_cfg),
            .sw_write_in   (wr_ctrl),
            .sw_value_in   (sw_val_vec[ch]),
            .vector_ack_in (vector_ack_in[ch]),
            .pending_out   (pend_vec[ch]),
            .active_out    (act_vec[ch]),
            .event_out     (evt_vec[ch])
        );
    end

    // =========================================================
    // control and config registers
    always_comb begin
        run_next  = run_reg;
        trig_next = trig_reg;
        pol_next  = pol_reg;
        gate_next = gate_reg;
        mask_next = mask_reg;
        if (wr_ctrl) begin
            run_next     = req.wdata[CTRL_TR0];
            trig_next[0] = req.wdata[CTRL_IT0];
            trig_next[1] = req.wdata[CTRL_IT1];
        end
        if (wr_cfg) begin
            pol_next[0] = req.wdata[CFG_POL0];
            pol_next[1] = req.wdata[CFG_POL1];
        end
        if (wr_gate) begin
            gate_next = req.wdata[GATE_SEL0];
        end
        if (wr_mask) begin
            mask_next = req.wdata[NUM_CH-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            run_reg  <= RUN_RST;
            trig_reg <= TRIG_RST;
            pol_reg  <= POL_RST;
            gate_reg <= GATE_RST;
            mask_reg <= MASK_RST;
        end else begin
            run_reg  <= run_next;
            trig_reg <= trig_next;
            pol_reg  <= pol_next;
            gate_reg <= gate_next;
            mask_reg <= mask_next;
        end
    end

    // =========================================================
    // sticky status and summary interrupt
    always_comb begin
        // write one clears; a new event in the same cycle wins
        stat_next = stat_reg;
        if (wr_stat) begin
            stat_next = stat_reg & ~req.wdata[NUM_CH-1:0];
        end
        stat_next = stat_next | evt_vec;
        irq_next  = |(stat_reg & mask_reg);
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg <= STAT_RST;
            irq_reg  <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq_reg  <= irq_next;
        end
    end

    // =========================================================
    // timer 0 count enable
    always_comb begin
        // gate uses the active level of interrupt 0 after polarity
        cnt_en_next = run_reg & (~gate_reg | act_vec[0]);
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cnt_en_reg <= 1'b0;
        end else begin
            cnt_en_reg <= cnt_en_next;
        end
    end

    // =========================================================
    // outputs
    always_comb begin
        prdata_out              = prdata_reg;
        pready_out              = pready_reg;
        pslverr_out             = pslverr_reg;
        ext_irq_pending_out     = pend_vec;
        timer0_count_enable_out = cnt_en_reg;
        irq_out                 = irq_reg;
    end

endmodule : eit_top

// >>> bench/eit_top_properties.sv
// Purpose: concurrent checks on the external interrupt flag block ports
// Assumes: one clock domain, apb writes seen at pready
// Notes:   shadows trigger, polarity, run and gate bits from apb writes
`timescale 1ns/10ps
module eit_top_properties
    import eit_pkg::*;
#(
    parameter int NUM_CH = NUM_EXT_IRQ
) (
    input wire logic              clk_in,
    input wire logic              reset_n_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic              pwrite_in,
    input wire logic [APB_AW-1:0] paddr_in,
    input wire logic [APB_DW-1:0] pwdata_in,
    input wire logic              pready_out,
    input wire logic              ext_irq0_input_in,
    input wire logic              ext_irq1_input_in,
    input wire logic [NUM_CH-1:0] vector_ack_in,
    input wire logic [NUM_CH-1:0] ext_irq_pending_out,
    input wire logic              timer0_count_enable_out
);
    // ====================
    // shadow: 0 trig0, 1 trig1, 2 pol0, 3 pol1, 4 run, 5 gate
    logic [5:0] sh_reg;
    logic [5:0] sh_next;
    logic       wr;
    logic       act0;
    logic       act1;
    assign wr   = psel_in && penable_in && pready_out && pwrite_in;
    assign act0 = (ext_irq0_input_in == sh_reg[2]);
    assign act1 = (ext_irq1_input_in == sh_reg[3]);
    always_comb begin
        sh_next = sh_reg;
        if (wr && paddr_in == CTRL_OFF) begin
            sh_next[1:0] = {pwdata_in[CTRL_IT1], pwdata_in[CTRL_IT0]};
            sh_next[4]   = pwdata_in[CTRL_TR0];
        end
        if (wr && paddr_in == CFG_OFF) begin
            sh_next[3:2] = pwdata_in[1:0];
        end
        if (wr && paddr_in == GATE_OFF) begin
            sh_next[5] = pwdata_in[GATE_SEL0];
        end
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) sh_reg <= '0;
        else sh_reg <= sh_next;
    end
    // ====================
    // properties
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_run_off; (!sh_reg[4]) [*3] |-> !timer0_count_enable_out; endproperty
    a_run_off: assert property (p_run_off) else $error("count without run bit");
    property p_run_on; (sh_reg[4] && !sh_reg[5]) [*3] |-> timer0_count_enable_out; endproperty
    a_run_on: assert property (p_run_on) else $error("run bit not counting");
    property p_gate_block; (sh_reg[4] && sh_reg[5] && !act0) [*3] |-> !timer0_count_enable_out;
    endproperty
    a_gate_block: assert property (p_gate_block) else $error("gate ignored");
    property p_gate_pass; (sh_reg[4] && sh_reg[5] && act0) [*3] |-> timer0_count_enable_out;
    endproperty
    a_gate_pass: assert property (p_gate_pass) else $error("gated count missing");
    property p_level_set0; (!sh_reg[0] && act0) [*3] |-> ext_irq_pending_out[0]; endproperty
    a_level_set0: assert property (p_level_set0) else $error("level 0 miss");
    property p_edge_set0;
        sh_reg[0] && !act0 ##1 sh_reg[0] && act0 |-> ##[1:2] ext_irq_pending_out[0];
    endproperty
    a_edge_set0: assert property (p_edge_set0) else $error("edge 0 not pending");
    property p_vec_clear0;
        sh_reg[0] && vector_ack_in[0] && $stable(act0) && act0 == $past(act0, 2)
        ##1 $stable(act0) |-> ##[0:1] !ext_irq_pending_out[0];
    endproperty
    a_vec_clear0: assert property (p_vec_clear0) else $error("vector did not clear");
    property p_sw_clear0;
        wr && paddr_in == CTRL_OFF && pwdata_in[CTRL_IT0] && !pwdata_in[CTRL_IE0] && sh_reg[0]
        && $stable(act0) && act0 == $past(act0, 2) |-> ##[1:2] !ext_irq_pending_out[0];
    endproperty
    a_sw_clear0: assert property (p_sw_clear0) else $error("write did not clear");
    property p_level_set1; (!sh_reg[1] && act1) [*3] |-> ext_irq_pending_out[1]; endproperty
    a_level_set1: assert property (p_level_set1) else $error("level 1 not pending");
endmodule : eit_top_properties

bind eit_top eit_top_properties #(.NUM_CH(NUM_CH)) u_props (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .ext_irq0_input_in(ext_irq0_input_in),
    .ext_irq1_input_in(ext_irq1_input_in), .vector_ack_in(vector_ack_in),
    .ext_irq_pending_out(ext_irq_pending_out),
    .timer0_count_enable_out(timer0_count_enable_out)
);

// >>> bench/eit_core_model.sv
// Purpose: external pins and core vectoring acknowledge
// Assumes: pins synchronous to clk_in, both idle high
// Notes:   changes only just after a rising edge
`timescale 1ns/10ps
module eit_core_model (
    input  wire logic  clk_in,
    output logic       ext_irq0_input_out,
    output logic       ext_irq1_input_out,
    output logic [1:0] vector_ack_out
);
    initial begin
        ext_irq0_input_out = 1'b1;
        ext_irq1_input_out = 1'b1;
        vector_ack_out     = 2'b00;
    end
    task automatic drive(input int ch, input logic lvl);
        @(posedge clk_in);
        if (ch == 0) ext_irq0_input_out <= lvl;
        else ext_irq1_input_out <= lvl;
    endtask : drive
    // one-cycle pulse, as the core vectors once per entry
    task automatic vector(input int ch);
        @(posedge clk_in);
        vector_ack_out <= 2'b01 << ch;
        @(posedge clk_in);
        vector_ack_out <= 2'b00;
    endtask : vector
endmodule : eit_core_model

// >>> bench/tb.sv
// Purpose: self-checking bench for the external interrupt flag block
// Assumes: zero wait state apb slave, pins from the core model
// Notes:   apb results queue up; a monitor pops them at pready
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import eit_pkg::*;
    typedef struct {logic [31:0] d; logic e; logic c;} eit_exp_t;
    logic              clk_in = 1'b0;
    logic              reset_n_in = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [APB_DW-1:0] pwdata = '0;
    logic [APB_DW-1:0] prdata;
    logic              pready, pslverr, pin0, pin1, ten, irq;
    logic [1:0]        ack, pend;
    int                num_errors = 0;
    int                comparisons = 0;
    eit_exp_t          expq[$];
    eit_exp_t          x;
    always #20 clk_in = ~clk_in;
    eit_top u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .ext_irq0_input_in(pin0), .ext_irq1_input_in(pin1), .vector_ack_in(ack),
        .ext_irq_pending_out(pend), .timer0_count_enable_out(ten), .irq_out(irq));
    eit_core_model u_core (.clk_in(clk_in), .ext_irq0_input_out(pin0),
        .ext_irq1_input_out(pin1), .vector_ack_out(ack));
    // ====================
    // monitor: oldest note against each answer
    always @(posedge clk_in) begin
        if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
            x = expq.pop_front();
            if (x.c) `CHK(prdata, x.d)
            `CHK(pslverr, x.e)
        end
    end
    task automatic stop_test();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       input logic [31:0] ed, input logic ee);
        int n;
        expq.push_back('{ed, ee, !w});
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_in);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            num_errors++;
            stop_test();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 32'h0, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed);
        apb(a, 1'b0, 32'h0, ed, 1'b0);
    endtask : rd
    // fixed wait: pending one cycle, irq one more
    task automatic settle();
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
    endtask : settle
    // ====================
    // main sequence
    initial begin
        void'($urandom(32'hc660));
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
        apb(8'h18, 1'b0, 32'h0, 32'h0, 1'b1); // unmapped
        apb(8'h01, 1'b1, 32'h1, 32'h0, 1'b1); // misaligned
        // channel 1 turned active high while its pin is high
        wr(CFG_OFF, 32'h2);
        settle();
        `CHK(pend, 2'b10)
        u_core.drive(1, 1'b0);
        wr(CTRL_OFF, 32'h0);
        wr(STAT_OFF, 32'h3);
        for (int ch = 0; ch < 2; ch++) begin
            wr(CTRL_OFF, ($urandom & 32'hffff_ffe0) | 32'h5);
            rd(CTRL_OFF, 32'h5);
            u_core.drive(ch, ch[0]);
            settle();
            `CHK(pend[ch], 1'b1)
            u_core.vector(ch);
            settle();
            `CHK(pend[ch], 1'b0)
            u_core.drive(ch, !ch[0]);
            u_core.drive(ch, ch[0]);
            settle();
            `CHK(pend[ch], 1'b1)
            wr(CTRL_OFF, 32'h5);
            settle();
            `CHK(pend[ch], 1'b0)
            wr(CTRL_OFF, 32'h0);
            u_core.drive(ch, !ch[0]);
            u_core.vector(ch);
            settle();
            `CHK(pend[ch], 1'b1)
            wr(CTRL_OFF, 32'h0);
            settle();
            `CHK(pend[ch], 1'b0)
        end
        // sticky status, mask and summary interrupt
        rd(STAT_OFF, 32'h3);
        `CHK(irq, 1'b0)
        wr(MASK_OFF, 32'h1);
        settle();
        `CHK(irq, 1'b1)
        wr(STAT_OFF, 32'h1);
        settle();
        `CHK(irq, 1'b0)
        rd(STAT_OFF, 32'h2);
        wr(MASK_OFF, 32'h3);
        settle();
        `CHK(irq, 1'b1)
        wr(STAT_OFF, 32'h2);
        settle();
        `CHK(irq, 1'b0)
        // timer 0 run and gate
        wr(CTRL_OFF, 32'h10);
        settle();
        `CHK(ten, 1'b1)
        wr(GATE_OFF, 32'h1);
        settle();
        `CHK(ten, 1'b0)
        u_core.drive(0, 1'b0);
        settle();
        `CHK(ten, 1'b1)
        rd(STATE_OFF, 32'h5);
        wr(CTRL_OFF, 32'h0);
        settle();
        `CHK(ten, 1'b0)
        stop_test();
    end
endmodule : tb
